// [rtl/fbdiv_pd_cfg.svh]
// register offsets, field positions, reset values and timing counts
`ifndef FBDIV_PD_CFG_SVH
`define FBDIV_PD_CFG_SVH
`define OFS_FBDIV_HIGH     12'h166
`define OFS_FBDIV_MID      12'h167
`define OFS_FBDIV_LOW      12'h168
`define OFS_PD_CTRL        12'h169
`define OFS_CAL_DIV_HIGH   12'h163
`define OFS_CAL_DIV_MID    12'h164
`define OFS_CAL_DIV_LOW    12'h165
`define OFS_LOOP_CTRL      12'h170
`define OFS_LOOP_STATUS    12'h174
`define RST_FBDIV_HIGH     8'h00
`define RST_FBDIV_MID      8'h00
`define RST_FBDIV_LOW      8'h0c
`define RST_PD_CTRL        8'h59
`define RST_FBDIV_RATIO    18'h0000c
`define RST_CAL_DIV_LOW    8'h0c
`define BIT_FCAL_DIS       2
`define BIT_CP_POL         2
`define BIT_CP_HIGHZ       1
`define BIT_PD_FIXED       0
`define POS_WND_LSB        5
`define POS_CP_GAIN_LSB    3
`define WND_CODE_3P7NS     2'h2
`define WND_3P7_PS         3700
`define CLK_PERIOD_PS      10000
`define WND_3P7_CYC        ((`WND_3P7_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CAL_TIME_CYC       64
`endif

// [rtl/fbdiv_pd_pkg.sv]
// types shared by the synthesizer loop configuration slice
package fbdiv_pd_pkg;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN  = 2'b01
  } cal_state_t;
  typedef logic [17:0] divide_ratio_t;
endpackage : fbdiv_pd_pkg

// [rtl/lock_window_counter.sv]
// counts consecutive phase comparisons that fall inside the lock window
`timescale 1ns/1ps
`include "fbdiv_pd_cfg.svh"
module lock_window_counter #(
  parameter int CNT_W = 16
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             phase_sample,
  input  wire logic [15:0]      phase_error_ps,
  input  wire logic [1:0]       lock_window_size,
  input  wire logic             clear,
  output logic      [CNT_W-1:0] lock_count
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } st_t;
  st_t s_q;
  st_t s_d;
  logic in_window;

  always_comb begin
    // reserved window codes never count
    in_window = (lock_window_size == `WND_CODE_3P7NS) &&
                (32'(phase_error_ps) < 32'(`WND_3P7_PS));
    s_d = s_q;
    if (clear) begin
      s_d.cnt = '0;
    end else if (phase_sample) begin
      if (in_window) begin // [R5]
        if (s_q.cnt != {CNT_W{1'b1}}) begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end else begin
        s_d.cnt = '0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lock_count = s_q.cnt;
endmodule : lock_window_counter

// [rtl/synth_fbdiv_pd_config.sv]
// AHB-Lite register slice for the second loop divider and phase detector
//
// Overview of operation
// R1: low byte write starts calibration unless disabled
// R2: calibration disable is bit 2, resets zero
// R3: 18-bit divider from three bytes; zero invalid
// R4: lock window bits 6:5, code 2 3.7ns
// R5: lock counter increments only inside window
// R6: pump current bits 4:3, reset code 3
// R7: polarity bit 2: zero negative slope
// R8: bit 1 one puts pump high-z
// R9: software always writes one into bit 0
// R10: cascaded mode calibrates with calibration divider
// R11: divider ratio applies coherently on low write
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "fbdiv_pd_cfg.svh"
module synth_fbdiv_pd_config
  import fbdiv_pd_pkg::*;
#(
  parameter int CNT_W    = 16,
  parameter int CAL_CYC  = `CAL_TIME_CYC
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [11:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire logic                       phase_sample,
  input  wire logic [15:0]                phase_error_ps,
  output fbdiv_pd_pkg::divide_ratio_t     active_divide_ratio,
  output logic                            cal_busy,
  output logic      [1:0]                 charge_pump_current,
  output logic                            charge_pump_polarity,
  output logic                            charge_pump_high_z,
  output logic      [1:0]                 lock_window_size,
  output logic                            divide_ratio_invalid
);
  import fbdiv_pd_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic          wr_pend;
    logic [11:0]   wr_addr;
    logic [7:0]    fb_high;
    logic [7:0]    fb_mid;
    logic [7:0]    fb_low;
    logic [7:0]    pd_ctrl;
    logic [7:0]    cal_high;
    logic [7:0]    cal_mid;
    logic [7:0]    cal_low;
    logic          feedback_source_select;
    divide_ratio_t feedback_divide_ratio;
    divide_ratio_t active;
    cal_state_t    cal_st;
    logic [15:0]   cal_cnt;
    logic [31:0]   rdata;
    logic          invalid;
  } st_t;

  st_t s_q;
  st_t s_d;
  logic [CNT_W-1:0] lock_count;
  logic             lock_clear;
  logic [7:0]       wbyte;
  logic             rd_go;
  logic             wr_go;

  function automatic divide_ratio_t join_ratio(input logic [7:0] hi, input logic [7:0] mi,
                                               input logic [7:0] lo);
    join_ratio = {hi[1:0], mi, lo}; // [R3]
  endfunction : join_ratio

  function automatic logic [7:0] byte_mask(input logic [11:0] a);
    unique case (a)
      `OFS_FBDIV_HIGH, `OFS_CAL_DIV_HIGH: byte_mask = 8'h07;
      `OFS_PD_CTRL:                       byte_mask = 8'h7f;
      `OFS_LOOP_CTRL:                     byte_mask = 8'h01;
      default:                            byte_mask = 8'hff;
    endcase
  endfunction : byte_mask

  // ------------------------------------------------------------------
  // bus slave: zero wait states, writes land in the data phase
  // ------------------------------------------------------------------
  always_comb begin
    s_d   = s_q;
    wr_go = hsel && hready && htrans[1] && hwrite;
    rd_go = hsel && hready && htrans[1] && !hwrite;
    wbyte = hwdata[7:0] & byte_mask(s_q.wr_addr);
    lock_clear = 1'b0;

    s_d.wr_pend = wr_go;
    if (wr_go) begin
      // one register per word: the word index is the register offset
      s_d.wr_addr = {2'b00, haddr[11:2]};
    end

    if (s_q.wr_pend) begin
      unique case (s_q.wr_addr)
        `OFS_FBDIV_HIGH:   s_d.fb_high = wbyte; // [R2]
        `OFS_FBDIV_MID:    s_d.fb_mid = wbyte;
        `OFS_FBDIV_LOW: begin
          s_d.fb_low = wbyte;
          // upper bytes only staged until now
          s_d.feedback_divide_ratio = join_ratio(s_q.fb_high, s_q.fb_mid, wbyte); // [R11]
          if (!s_q.fb_high[`BIT_FCAL_DIS]) begin // [R1]
            s_d.cal_st  = CAL_RUN;
            s_d.cal_cnt = '0;
            lock_clear  = 1'b1;
            s_d.active  = s_q.feedback_source_select ? // [R10]
                          join_ratio(s_q.cal_high, s_q.cal_mid, s_q.cal_low) :
                          join_ratio(s_q.fb_high, s_q.fb_mid, wbyte);
          end else begin
            s_d.cal_st = CAL_IDLE;
            s_d.active = join_ratio(s_q.fb_high, s_q.fb_mid, wbyte); // [R11]
          end
        end
        // bit 0 kept as written; software must write one
        `OFS_PD_CTRL:      s_d.pd_ctrl = wbyte; // [R9]
        `OFS_CAL_DIV_HIGH: s_d.cal_high = wbyte;
        `OFS_CAL_DIV_MID:  s_d.cal_mid = wbyte;
        `OFS_CAL_DIV_LOW:  s_d.cal_low = wbyte;
        `OFS_LOOP_CTRL:    s_d.feedback_source_select = wbyte[0];
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // calibration sequencer
    // ----------------------------------------------------------------
    if (s_q.cal_st == CAL_RUN && !(s_q.wr_pend && s_q.wr_addr == `OFS_FBDIV_LOW)) begin
      if (32'(s_q.cal_cnt) >= CAL_CYC - 1) begin
        s_d.cal_st = CAL_IDLE;
        s_d.active = s_q.feedback_divide_ratio; // [R10]
      end else begin
        s_d.cal_cnt = s_q.cal_cnt + 16'h0001;
      end
    end

    s_d.invalid = (s_d.active == '0); // [R3]

    if (rd_go) begin
      unique case ({2'b00, haddr[11:2]})
        `OFS_FBDIV_HIGH:   s_d.rdata = {24'h0, s_q.fb_high};
        `OFS_FBDIV_MID:    s_d.rdata = {24'h0, s_q.fb_mid};
        `OFS_FBDIV_LOW:    s_d.rdata = {24'h0, s_q.fb_low};
        `OFS_PD_CTRL:      s_d.rdata = {24'h0, s_q.pd_ctrl};
        `OFS_CAL_DIV_HIGH: s_d.rdata = {24'h0, s_q.cal_high};
        `OFS_CAL_DIV_MID:  s_d.rdata = {24'h0, s_q.cal_mid};
        `OFS_CAL_DIV_LOW:  s_d.rdata = {24'h0, s_q.cal_low};
        `OFS_LOOP_CTRL:    s_d.rdata = {31'h0, s_q.feedback_source_select};
        `OFS_LOOP_STATUS:  s_d.rdata = {s_q.cal_st == CAL_RUN, s_q.invalid,
                                        14'(lock_count), 16'h0};
        default:           s_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q.wr_pend  <= 1'b0;
      s_q.wr_addr  <= 12'h000;
      s_q.fb_high  <= `RST_FBDIV_HIGH;
      s_q.fb_mid   <= `RST_FBDIV_MID;
      s_q.fb_low   <= `RST_FBDIV_LOW;
      s_q.pd_ctrl  <= `RST_PD_CTRL; // [R4] [R6] [R7] [R8]
      s_q.cal_high <= 8'h00;
      s_q.cal_mid  <= 8'h00;
      s_q.cal_low  <= `RST_CAL_DIV_LOW;
      s_q.feedback_source_select <= 1'b0;
      s_q.feedback_divide_ratio  <= `RST_FBDIV_RATIO;
      s_q.active   <= `RST_FBDIV_RATIO;
      s_q.cal_st   <= CAL_IDLE;
      s_q.cal_cnt  <= 16'h0000;
      s_q.rdata    <= 32'h0;
      s_q.invalid  <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  lock_window_counter #(
    .CNT_W(CNT_W)
  ) u_lock (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .phase_sample    (phase_sample),
    .phase_error_ps  (phase_error_ps),
    .lock_window_size(s_q.pd_ctrl[`POS_WND_LSB+1:`POS_WND_LSB]), // [R4]
    .clear           (lock_clear),
    .lock_count      (lock_count)
  );

  // ------------------------------------------------------------------
  // outputs, flop-driven except hreadyout and hresp, which are tied to constants
  // ------------------------------------------------------------------
  assign hrdata               = s_q.rdata;
  assign hreadyout            = 1'b1;
  assign hresp                = 1'b0;
  assign active_divide_ratio  = s_q.active;
  assign cal_busy             = (s_q.cal_st == CAL_RUN);
  assign charge_pump_current  = s_q.pd_ctrl[`POS_CP_GAIN_LSB+1:`POS_CP_GAIN_LSB]; // [R6]
  assign charge_pump_polarity = s_q.pd_ctrl[`BIT_CP_POL]; // [R7]
  assign charge_pump_high_z   = s_q.pd_ctrl[`BIT_CP_HIGHZ]; // [R8]
  assign lock_window_size     = s_q.pd_ctrl[`POS_WND_LSB+1:`POS_WND_LSB];
  assign divide_ratio_invalid = s_q.invalid;
endmodule : synth_fbdiv_pd_config

// [tb/fbdiv_pd_properties.sv]
// property checker for the loop divider and phase detector slice
`timescale 1ns/1ps
`include "fbdiv_pd_cfg.svh"
module fbdiv_pd_checker
  import fbdiv_pd_pkg::*;
#(
  parameter int CAL_CYC = 4
) (
  input wire logic                        hclk,
  input wire logic                        hresetn,
  input wire logic                        hsel,
  input wire logic [11:0]                 haddr,
  input wire logic [1:0]                  htrans,
  input wire logic                        hwrite,
  input wire logic [31:0]                 hwdata,
  input wire logic                        hready,
  input wire fbdiv_pd_pkg::divide_ratio_t active_divide_ratio,
  input wire logic                        cal_busy,
  input wire logic [1:0]                  charge_pump_current,
  input wire logic                        charge_pump_polarity,
  input wire logic                        charge_pump_high_z,
  input wire logic [1:0]                  lock_window_size
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ------
  // shadow of host writes
  // ------
  wire logic  take = hsel && hready && htrans[1] && hwrite;
  logic       w_hi_q, w_mid_q, w_lo_q, w_pd_q, dis_q;
  logic [1:0] n_hi_q;
  logic [7:0] n_mid_q;
  int         busy_n_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {w_hi_q, w_mid_q, w_lo_q, w_pd_q, dis_q, n_hi_q, n_mid_q} <= '0;
      busy_n_q <= 0;
    end else begin
      busy_n_q <= cal_busy ? busy_n_q + 1 : 0;
      if (hready) begin
        w_hi_q  <= take && haddr == (`OFS_FBDIV_HIGH << 2);
        w_mid_q <= take && haddr == (`OFS_FBDIV_MID << 2);
        w_lo_q  <= take && haddr == (`OFS_FBDIV_LOW << 2);
        w_pd_q  <= take && haddr == (`OFS_PD_CTRL << 2);
        if (w_hi_q) {dis_q, n_hi_q} <= hwdata[2:0];
        if (w_mid_q) n_mid_q <= hwdata[7:0];
      end
    end
  end
  AST_CP_CURRENT: assert property (w_pd_q |=> charge_pump_current == $past(hwdata[4:3]))
    else $error("pump current not as written");
  AST_CP_POL: assert property (w_pd_q |=> charge_pump_polarity == $past(hwdata[2]))
    else $error("pump polarity not as written");
  AST_CP_HIGHZ: assert property (w_pd_q |=> charge_pump_high_z == $past(hwdata[1]))
    else $error("pump high-z not as written");
  AST_WND: assert property (w_pd_q |=> lock_window_size == $past(hwdata[6:5]))
    else $error("lock window not as written");
  AST_CAL_START: assert property (w_lo_q && !dis_q && !cal_busy |=> cal_busy)
    else $error("low byte write did not start calibration");
  AST_CAL_CAUSE: assert property ($rose(cal_busy) |-> $past(w_lo_q) && !$past(dis_q))
    else $error("calibration started without enabled low write");
  AST_CAL_LEN: assert property ($fell(cal_busy) && busy_n_q != 0 |-> busy_n_q == CAL_CYC)
    else $error("calibration length wrong");
  AST_DIS_APPLY: assert property (w_lo_q && dis_q |=>
    active_divide_ratio == {$past(n_hi_q), $past(n_mid_q), $past(hwdata[7:0])})
    else $error("divider not applied on low write");
  AST_RATIO_HELD: assert property ($changed(active_divide_ratio) |->
    $past(w_lo_q) || $past(cal_busy))
    else $error("divider changed without low write");
endmodule : fbdiv_pd_checker

// [tb/synth_fbdiv_pd_config_test.sv]
// self-checking bench for the loop divider and phase detector slice
`timescale 1ns/1ps
`include "fbdiv_pd_cfg.svh"
module synth_fbdiv_pd_config_test;
  import fbdiv_pd_pkg::*;
  localparam int CAL_CYC = 4;
  logic          hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, phase_sample = 0, rd_ph = 0;
  logic [11:0]   haddr = '0;
  logic [1:0]    htrans = '0, charge_pump_current, lock_window_size;
  logic [2:0]    hsize = 3'h2;
  logic [31:0]   hwdata = '0, hrdata;
  logic [15:0]   phase_error_ps = '0;
  logic [15:0]   ph_e = '0;
  logic          ph_hold = 0, ph_s = 0;
  logic          hreadyout, hresp, cal_busy, charge_pump_polarity, charge_pump_high_z;
  logic          divide_ratio_invalid;
  divide_ratio_t active_divide_ratio;
  logic [31:0]   exp_q[$];
  int            miscompares = 0, tests_run = 0;
  wire logic [5:0]  pd_out = {lock_window_size, charge_pump_current, charge_pump_polarity,
                              charge_pump_high_z};
  wire logic [31:0] ratio_w = {13'h0, divide_ratio_invalid, active_divide_ratio};
  synth_fbdiv_pd_config #(.CAL_CYC(CAL_CYC)) u_synth_fbdiv_pd_config (.hready(hreadyout), .*);
  initial forever #5 hclk = ~hclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      miscompares++;
    end
  endtask : chk
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // bounded waits: a hang counts as a mismatch
  task automatic wait_on(input logic v, input logic rdy);
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while ((rdy ? hreadyout : cal_busy) !== v && n < 200);
    if (n >= 200) begin
      miscompares++;
      print_verdict();
    end
  endtask : wait_on
  task automatic bus(input logic [11:0] ofs, input logic wr, input logic [7:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= ofs << 2;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_on(1'b1, 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_on(1'b1, 1'b1);
  endtask : bus
  task automatic rd(input logic [11:0] ofs, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(ofs, 1'b0, 8'h0);
  endtask : rd
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1) begin
      chk("hrdata", exp_q.pop_front(), hrdata);
      chk("hresp", 32'h0, {31'h0, hresp});
    end
    if (hreadyout === 1'b1) rd_ph <= hsel && htrans[1] && !hwrite;
  end
  always @(posedge hclk) begin
    if (ph_hold) begin
      phase_sample   <= ph_s;
      phase_error_ps <= ph_e;
    end else begin
      phase_sample   <= 1'($urandom);
      phase_error_ps <= 16'($urandom_range(8000));
    end
  end
  initial begin
    logic [17:0] r, rc;
    logic [7:0]  pd;
    logic        seen;
    void'($urandom(32'h64938966));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`OFS_FBDIV_HIGH, 8'h00);
    rd(`OFS_FBDIV_MID, 8'h00);
    rd(`OFS_PD_CTRL, 8'h59);
    chk("pd_ports", 32'h2c, {26'h0, pd_out});
    chk("ratio", 32'hc, ratio_w);
    $display("reset values done");
    for (int c = 0; c < 4; c++) begin
      pd = {3'($urandom), 2'(c), 2'($urandom), 1'b1};
      bus(`OFS_PD_CTRL, 1'b1, pd);
      rd(`OFS_PD_CTRL, pd & 8'h7f);
      chk("pd_ports", {26'h0, pd[6:1]}, {26'h0, pd_out});
    end
    $display("phase detector fields done");
    // window 3.7 ns; edge samples at 3700 ps clear, five at 3699 ps count
    bus(`OFS_PD_CTRL, 1'b1, 8'h59);
    ph_hold <= 1'b1;
    ph_s    <= 1'b1;
    ph_e    <= 16'd3700;
    repeat (3) @(posedge hclk);
    ph_e    <= 16'd3699;
    repeat (5) @(posedge hclk);
    ph_s    <= 1'b0;
    repeat (3) @(posedge hclk);
    exp_q.push_back(32'h0005_0000);
    bus(`OFS_LOOP_STATUS, 1'b0, 8'h0);
    ph_hold <= 1'b0;
    $display("lock counter done");
    r = 18'($urandom) | 18'h1;
    bus(`OFS_FBDIV_HIGH, 1'b1, {5'($urandom), 1'b0, r[17:16]});
    bus(`OFS_FBDIV_MID, 1'b1, r[15:8]);
    chk("ratio_held", 32'hc, ratio_w);
    bus(`OFS_FBDIV_LOW, 1'b1, r[7:0]);
    wait_on(1'b1, 1'b0);
    wait_on(1'b0, 1'b0);
    chk("ratio", {14'h0, r}, ratio_w);
    rd(`OFS_FBDIV_HIGH, {6'h0, r[17:16]});
    rd(`OFS_FBDIV_LOW, r[7:0]);
    $display("calibrated divider done");
    bus(`OFS_FBDIV_HIGH, 1'b1, 8'h04);
    bus(`OFS_FBDIV_MID, 1'b1, 8'h00);
    bus(`OFS_FBDIV_LOW, 1'b1, 8'h00);
    seen = 1'b0;
    repeat (2 * CAL_CYC) begin
      @(posedge hclk);
      seen |= cal_busy !== 1'b0;
    end
    chk("cal_skipped", 32'h0, {31'h0, seen});
    chk("zero_ratio", 32'h40000, ratio_w);
    rd(12'h16a, 8'h00);
    $display("disabled calibration done");
    rc = 18'($urandom) | 18'h1;
    rd(`OFS_CAL_DIV_LOW, 8'h0c);
    bus(`OFS_LOOP_CTRL, 1'b1, 8'hff);
    rd(`OFS_LOOP_CTRL, 8'h01);
    bus(`OFS_CAL_DIV_HIGH, 1'b1, {6'h0, rc[17:16]});
    bus(`OFS_CAL_DIV_MID, 1'b1, rc[15:8]);
    bus(`OFS_CAL_DIV_LOW, 1'b1, rc[7:0]);
    bus(`OFS_FBDIV_HIGH, 1'b1, {6'h0, r[17:16]});
    bus(`OFS_FBDIV_MID, 1'b1, r[15:8]);
    bus(`OFS_FBDIV_LOW, 1'b1, r[7:0]);
    wait_on(1'b1, 1'b0);
    chk("cal_ratio", {14'h0, rc}, ratio_w);
    wait_on(1'b0, 1'b0);
    chk("ratio", {14'h0, r}, ratio_w);
    $display("cascaded calibration done");
    print_verdict();
  end
endmodule : synth_fbdiv_pd_config_test
bind synth_fbdiv_pd_config fbdiv_pd_checker #(.CAL_CYC(CAL_CYC)) u_fbdiv_pd_checker (.*);
